// *** core/cre_consts.vh ***
// constants for the receiver interrupt enable block
// How it works
// - init mode holds enable gate bits at reset
// - enable writes only with both handshake bits low; reads anytime
// - sensitivity fields survive init mode
// - bit 7 gates wake-up request
// - bit 6 gates status-change error request
// - bits 5-4 pick receiver change sensitivity
// - bits 3-2 pick transmitter change sensitivity
// - state flags track, frozen while flag pending
// - bit 1 gates overrun error request
// - bit 0 gates receive-full request
// - tx leaving bus-off for active forces rx active
// - one enable per transmit empty flag
// - bus status change selected by sensitivity sets change flag
// - receive counter below 96 means active
// - bus-off only when tx counter exceeds 255
`ifndef CRE_CONSTS_VH
`define CRE_CONSTS_VH

// register byte offsets
`define CRE_OFS_RX_FLAGS   6'h04
`define CRE_OFS_RX_IRQ_EN  6'h05
`define CRE_OFS_TX_FLAGS   6'h06
`define CRE_OFS_TX_IRQ_EN  6'h07

// field positions in flags and enable registers
`define CRE_BIT_WAKEUP     7
`define CRE_BIT_STATUS     6
`define CRE_BIT_OVERRUN    1
`define CRE_BIT_RXFULL     0
`define CRE_RX_SENS_HI     5
`define CRE_RX_SENS_LO     4
`define CRE_TX_SENS_HI     3
`define CRE_TX_SENS_LO     2

// reset values
`define CRE_RX_IRQ_EN_RST  8'h00
`define CRE_TX_IRQ_EN_RST  3'h0

// error state codes
`define CRE_ST_ACTIVE      2'h0
`define CRE_ST_WARNING     2'h1
`define CRE_ST_PASSIVE     2'h2
`define CRE_ST_BUSOFF      2'h3

// error counter thresholds
`define CRE_LIM_WARNING    9'h060
`define CRE_LIM_PASSIVE    9'h080
`define CRE_LIM_BUSOFF     9'h0ff

// sensitivity codes
`define CRE_SENS_NONE      2'h0
`define CRE_SENS_BUSOFF    2'h1
`define CRE_SENS_PASSIVE   2'h2
`define CRE_SENS_ALL       2'h3

`endif

// *** core/cre_rx_irq.v ***
// receiver interrupt enable, status-change tracking and request gating
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cre_consts.vh"

module cre_rx_irq (
  input  wire       sys_clk_i,       // module clock, 250 MHz
  input  wire       rst_i,           // async reset, active high
  input  wire [5:0] addr_i,          // register byte address
  input  wire [7:0] wdata_i,         // write data
  input  wire       wr_i,            // write strobe
  input  wire       rd_i,            // read strobe
  output reg  [7:0] rdata_o,         // read data, cycle after rd_i
  input  wire       init_request_i,  // init mode requested
  input  wire       init_acknowledge_i, // init mode acknowledged
  input  wire [8:0] tec_i,           // transmit error counter
  input  wire [8:0] rec_i,           // receive error counter
  input  wire       wakeup_evt_i,    // wake-up event pulse
  input  wire       overrun_evt_i,   // overrun event pulse
  input  wire       rx_full_evt_i,   // good message stored pulse
  input  wire [2:0] tx_empty_flags_i, // transmit buffer empty levels
  output reg        wakeup_irq_o,    // wake-up request
  output reg        error_irq_o,     // error request
  output reg        rx_irq_o,        // receiver request
  output reg        tx_irq_o,        // transmitter empty request
  output reg        irq_o,           // any unmasked request
  output reg  [1:0] rx_error_state_o, // shown receiver state
  output reg  [1:0] tx_error_state_o  // shown transmitter state
);

  // error state of a counter, four codes
  function [1:0] cnt_state;
    input [8:0] cnt;
    begin
      if (cnt > `CRE_LIM_BUSOFF) begin
        cnt_state = `CRE_ST_BUSOFF;
      end else if (cnt >= `CRE_LIM_PASSIVE) begin
        cnt_state = `CRE_ST_PASSIVE;
      end else if (cnt >= `CRE_LIM_WARNING) begin
        cnt_state = `CRE_ST_WARNING;
      end else begin
        cnt_state = `CRE_ST_ACTIVE;
      end
    end
  endfunction

  // does a move from old to new matter at this sensitivity
  function sens_hit;
    input [1:0] sel;
    input [1:0] old_st;
    input [1:0] new_st;
    reg         old_bo;
    reg         new_bo;
    reg         old_ep;
    reg         new_ep;
    begin
      old_bo = (old_st == `CRE_ST_BUSOFF);
      new_bo = (new_st == `CRE_ST_BUSOFF);
      old_ep = (old_st >= `CRE_ST_PASSIVE);
      new_ep = (new_st >= `CRE_ST_PASSIVE);
      case (sel)
        `CRE_SENS_NONE: begin
          sens_hit = 1'b0;
        end
        `CRE_SENS_BUSOFF: begin
          sens_hit = (old_bo != new_bo);
        end
        `CRE_SENS_PASSIVE: begin
          sens_hit = (old_ep != new_ep);
        end
        default: begin
          sens_hit = (old_st != new_st);
        end
      endcase
    end
  endfunction

  // registers
  reg  [7:0] rx_irq_en_q;  // gate and sensitivity bits
  reg  [7:0] rx_irq_en_d;
  reg  [2:0] tx_irq_en_q;
  reg  [2:0] tx_irq_en_d;
  reg        wake_flag_q;
  reg        wake_flag_d;
  reg        status_change_flag_q;
  reg        status_change_flag_d;
  reg        ovr_flag_q;
  reg        ovr_flag_d;
  reg        rxf_flag_q;
  reg        rxf_flag_d;
  reg  [1:0] rx_st_q;
  reg  [1:0] rx_st_d;
  reg  [1:0] tx_st_q;
  reg  [1:0] tx_st_d;
  reg  [7:0] rdata_d;

  // reset image as a parameter so single bits can be picked from it
  localparam [7:0] rx_en_rst = `CRE_RX_IRQ_EN_RST;

  // decode
  wire       init_mode;
  wire       wr_ok;
  wire       wr_flags;
  wire       wr_rx_en;
  wire       wr_tx_en;
  wire [1:0] tx_act;
  wire [1:0] rx_act;
  wire       tx_leave_bo;
  wire       rx_hit;
  wire       tx_hit;
  wire       change_set;
  wire [7:0] flags_rd;

  // request terms, one per output
  wire       req_wake;
  wire       req_err;
  wire       req_rx;
  wire       req_tx;

  // init mode needs both request and acknowledge
  assign init_mode = init_request_i & init_acknowledge_i;
  // enable writes only when neither handshake bit is up
  assign wr_ok    = ~init_request_i & ~init_acknowledge_i;
  assign wr_flags = wr_i & (addr_i == `CRE_OFS_RX_FLAGS);
  assign wr_rx_en = wr_i & wr_ok & (addr_i == `CRE_OFS_RX_IRQ_EN);
  assign wr_tx_en = wr_i & wr_ok & (addr_i == `CRE_OFS_TX_IRQ_EN);

  // actual bus states from the counters
  assign tx_act      = cnt_state(tec_i);
  // exit is judged on the shown tx state: a bus-off held by a pending
  // flag still forces the receiver active at the edge that releases it
  assign tx_leave_bo = (tx_st_q == `CRE_ST_BUSOFF) &&
                       (tx_act == `CRE_ST_ACTIVE);
  // receiver mirrors bus-off and is forced active when tx exits bus-off to active
  assign rx_act = (tx_act == `CRE_ST_BUSOFF) ? `CRE_ST_BUSOFF :
                  tx_leave_bo ? `CRE_ST_ACTIVE :
                  ((rec_i > `CRE_LIM_BUSOFF) ? `CRE_ST_PASSIVE :
                   cnt_state(rec_i));

  // sensitivity filters on shown versus actual state
  assign rx_hit = sens_hit(rx_irq_en_q[`CRE_RX_SENS_HI:`CRE_RX_SENS_LO],
                           rx_st_q, rx_act);
  assign tx_hit = sens_hit(rx_irq_en_q[`CRE_TX_SENS_HI:`CRE_TX_SENS_LO],
                           tx_st_q, tx_act);
  // blocking flag: nothing new is seen while one is pending
  assign change_set = ~status_change_flag_q & (rx_hit | tx_hit);

  // flags register image
  assign flags_rd = {wake_flag_q, status_change_flag_q, rx_st_q,
                     tx_st_q, ovr_flag_q, rxf_flag_q};

  // request terms, flag AND enable, shared by each output and the OR
  assign req_wake = wake_flag_q & rx_irq_en_q[`CRE_BIT_WAKEUP];
  assign req_err  = (status_change_flag_q & rx_irq_en_q[`CRE_BIT_STATUS]) |
                    (ovr_flag_q & rx_irq_en_q[`CRE_BIT_OVERRUN]);
  assign req_rx   = rxf_flag_q & rx_irq_en_q[`CRE_BIT_RXFULL];
  assign req_tx   = |(tx_empty_flags_i & tx_irq_en_q);

  // enable registers: init holds only the gate bits, not sensitivity
  always @* begin
    rx_irq_en_d = rx_irq_en_q;
    tx_irq_en_d = tx_irq_en_q;
    if (wr_rx_en) begin
      rx_irq_en_d = wdata_i;
    end
    if (wr_tx_en) begin
      tx_irq_en_d = wdata_i[2:0];
    end
    if (init_mode) begin
      rx_irq_en_d[`CRE_BIT_WAKEUP]  = rx_en_rst[`CRE_BIT_WAKEUP];
      rx_irq_en_d[`CRE_BIT_STATUS]  = rx_en_rst[`CRE_BIT_STATUS];
      rx_irq_en_d[`CRE_BIT_OVERRUN] = rx_en_rst[`CRE_BIT_OVERRUN];
      rx_irq_en_d[`CRE_BIT_RXFULL]  = rx_en_rst[`CRE_BIT_RXFULL];
      // sensitivity bits keep their value here
      rx_irq_en_d[`CRE_RX_SENS_HI:`CRE_TX_SENS_LO] =
        rx_irq_en_q[`CRE_RX_SENS_HI:`CRE_TX_SENS_LO];
      tx_irq_en_d = `CRE_TX_IRQ_EN_RST;
    end
  end

  // sticky flags, write one clears, a same-cycle event wins
  // so an event landing on a clear is never lost
  always @* begin
    wake_flag_d          = wake_flag_q;
    status_change_flag_d = status_change_flag_q;
    ovr_flag_d           = ovr_flag_q;
    rxf_flag_d           = rxf_flag_q;
    if (wr_flags) begin
      if (wdata_i[`CRE_BIT_WAKEUP]) begin
        wake_flag_d = 1'b0;
      end
      if (wdata_i[`CRE_BIT_STATUS]) begin
        status_change_flag_d = 1'b0;
      end
      if (wdata_i[`CRE_BIT_OVERRUN]) begin
        ovr_flag_d = 1'b0;
      end
      if (wdata_i[`CRE_BIT_RXFULL]) begin
        rxf_flag_d = 1'b0;
      end
    end
    if (wakeup_evt_i) begin
      wake_flag_d = 1'b1;
    end
    if (change_set) begin
      status_change_flag_d = 1'b1;
    end
    if (overrun_evt_i) begin
      ovr_flag_d = 1'b1;
    end
    if (rx_full_evt_i) begin
      rxf_flag_d = 1'b1;
    end
  end

  // shown states follow actual only while no change flag is pending
  // a clear lets them catch up with the counters at the next edge
  always @* begin
    rx_st_d = rx_st_q;
    tx_st_d = tx_st_q;
    if (~status_change_flag_q) begin
      rx_st_d = rx_act;
      tx_st_d = tx_act;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `CRE_OFS_RX_FLAGS: begin
          rdata_d = flags_rd;
        end
        `CRE_OFS_RX_IRQ_EN: begin
          rdata_d = rx_irq_en_q;
        end
        `CRE_OFS_TX_FLAGS: begin
          rdata_d = {5'h00, tx_empty_flags_i};
        end
        `CRE_OFS_TX_IRQ_EN: begin
          rdata_d = {5'h00, tx_irq_en_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // state flops
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_irq_en_q          <= `CRE_RX_IRQ_EN_RST;
      tx_irq_en_q          <= `CRE_TX_IRQ_EN_RST;
      wake_flag_q          <= 1'b0;
      status_change_flag_q <= 1'b0;
      ovr_flag_q           <= 1'b0;
      rxf_flag_q           <= 1'b0;
      rx_st_q              <= `CRE_ST_ACTIVE;
      tx_st_q              <= `CRE_ST_ACTIVE;
      rdata_o              <= 8'h00;
    end else begin
      rx_irq_en_q          <= rx_irq_en_d;
      tx_irq_en_q          <= tx_irq_en_d;
      wake_flag_q          <= wake_flag_d;
      status_change_flag_q <= status_change_flag_d;
      ovr_flag_q           <= ovr_flag_d;
      rxf_flag_q           <= rxf_flag_d;
      rx_st_q              <= rx_st_d;
      tx_st_q              <= tx_st_d;
      rdata_o              <= rdata_d;
    end
  end

  // requests: flag AND enable, registered so outputs come from flops;
  // this costs one cycle of lag behind the flag
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wakeup_irq_o     <= 1'b0;
      error_irq_o      <= 1'b0;
      rx_irq_o         <= 1'b0;
      tx_irq_o         <= 1'b0;
      irq_o            <= 1'b0;
      rx_error_state_o <= `CRE_ST_ACTIVE;
      tx_error_state_o <= `CRE_ST_ACTIVE;
    end else begin
      wakeup_irq_o <= req_wake;
      error_irq_o  <= req_err;
      rx_irq_o     <= req_rx;
      tx_irq_o     <= req_tx;
      irq_o        <= req_wake |
                      req_err |
                      req_rx |
                      req_tx;
      rx_error_state_o <= rx_st_q;
      tx_error_state_o <= tx_st_q;
    end
  end

endmodule
`default_nettype wire

// *** verification/cre_rx_irq_monitor.sv ***
// checker for request outputs and shown error states
`timescale 1ns/1ps
`default_nettype none
`include "cre_consts.vh"
module cre_rx_irq_monitor (
  input wire       sys_clk_i,          // clock
  input wire       rst_i,              // reset
  input wire       wr_i,               // write strobe
  input wire       rd_i,               // read strobe
  input wire [7:0] rdata_o,            // read data
  input wire       init_request_i,     // init request
  input wire       init_acknowledge_i, // init ack
  input wire [8:0] tec_i,              // tx count
  input wire       wakeup_evt_i,       // wake event
  input wire       rx_full_evt_i,      // full event
  input wire       wakeup_irq_o,       // wake req
  input wire       error_irq_o,        // error req
  input wire       rx_irq_o,           // rx req
  input wire       tx_irq_o,           // tx req
  input wire       irq_o,              // any req
  input wire [1:0] rx_error_state_o,   // rx state
  input wire [1:0] tx_error_state_o    // tx state
);
  logic in_init;
  // init mode seen as one signal so $past stays on a plain net
  assign in_init = init_request_i && init_acknowledge_i;
  // counter to state; bus-off only above 255
  function automatic [1:0] st(input [8:0] c);
    st = c > `CRE_LIM_BUSOFF ? `CRE_ST_BUSOFF : c >= `CRE_LIM_PASSIVE ? `CRE_ST_PASSIVE :
         c >= `CRE_LIM_WARNING ? `CRE_ST_WARNING : `CRE_ST_ACTIVE;
  endfunction
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  init_quiet_a:
    assert property (in_init [*3] |-> !(wakeup_irq_o || error_irq_o || rx_irq_o || tx_irq_o))
      else $error("request while in init mode");
  irq_or_a:
    assert property (irq_o == (wakeup_irq_o || error_irq_o || rx_irq_o || tx_irq_o))
      else $error("combined request mismatch");
  wake_rise_a:
    assert property ($rose(wakeup_irq_o) |-> $past(wakeup_evt_i, 2) || $past(wr_i, 2)
      || $past(wakeup_evt_i) || $past(wr_i)) else $error("wake request without cause");
  rxf_rise_a:
    assert property ($rose(rx_irq_o) |-> $past(rx_full_evt_i, 2) || $past(wr_i, 2)
      || $past(rx_full_evt_i) || $past(wr_i)) else $error("rx request without cause");
  rx_fall_a:
    assert property ($fell(rx_irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(in_init)
      || $past(in_init, 2)) else $error("rx request dropped without cause");
  rdata_slot_a:
    assert property (rdata_o != 8'h00 |-> $past(rd_i)) else $error("read data outside slot");
  tx_state_a:
    assert property ($changed(tx_error_state_o) |-> tx_error_state_o == st($past(tec_i))
      || tx_error_state_o == st($past(tec_i, 2))) else $error("tx state not from count");
  busoff_mirror_a:
    assert property (tx_error_state_o == `CRE_ST_BUSOFF |-> rx_error_state_o == `CRE_ST_BUSOFF)
      else $error("rx state not mirroring bus-off");
  rx_recover_a:
    assert property ($past(tx_error_state_o) == `CRE_ST_BUSOFF
      && tx_error_state_o == `CRE_ST_ACTIVE |-> rx_error_state_o == `CRE_ST_ACTIVE)
      else $error("rx state not forced active");
endmodule
bind cre_rx_irq cre_rx_irq_monitor u_mon (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .init_request_i(init_request_i), .init_acknowledge_i(init_acknowledge_i), .tec_i(tec_i),
  .wakeup_evt_i(wakeup_evt_i), .rx_full_evt_i(rx_full_evt_i), .wakeup_irq_o(wakeup_irq_o),
  .error_irq_o(error_irq_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .irq_o(irq_o),
  .rx_error_state_o(rx_error_state_o), .tx_error_state_o(tx_error_state_o));
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the receiver interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`include "cre_consts.vh"
module tb;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, ir = 0, ia = 0, we = 0, oe = 0, fe = 0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wd = 8'h00, rdata, d;
  logic [8:0] tec = 9'h000, rec = 9'h000;
  logic [2:0] tf = 3'h5;
  logic       wi, ei, ri, ti, io;
  logic [1:0] rs, ts;
  int         n_errors = 0;
  int         cmp_count = 0;
  // rows: enable address, enable value, event, expected {wake,err,rx,tx}
  // row 0 raises the wake gate and expects the wake request alone
  logic [19:0] rows [8] = '{{6'h05, 8'h80, 2'd0, 4'h8}, {6'h05, 8'h7f, 2'd0, 4'h0},
    {6'h05, 8'h02, 2'd1, 4'h4}, {6'h05, 8'hfd, 2'd1, 4'h0}, {6'h05, 8'h01, 2'd2, 4'h2},
    {6'h05, 8'hfe, 2'd2, 4'h0}, {6'h07, 8'h04, 2'd3, 4'h1}, {6'h07, 8'h02, 2'd3, 4'h0}};
  cre_rx_irq u_dut (
    .sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .init_request_i(ir), .init_acknowledge_i(ia), .tec_i(tec), .rec_i(rec),
    .wakeup_evt_i(we), .overrun_evt_i(oe), .rx_full_evt_i(fe), .tx_empty_flags_i(tf),
    .wakeup_irq_o(wi), .error_irq_o(ei), .rx_irq_o(ri), .tx_irq_o(ti), .irq_o(io),
    .rx_error_state_o(rs), .tx_error_state_o(ts));
  always #2 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input [5:0] a, input [7:0] v);
    @(posedge clk); wr <= 1; addr <= a; wd <= v;
    @(posedge clk); wr <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input [5:0] a, output [7:0] v);
    @(posedge clk); rd <= 1; addr <= a;
    @(posedge clk); rd <= 0;
    #1 v = rdata;
  endtask
  task automatic pulse(input [1:0] s);
    @(posedge clk); we <= (s == 2'd0); oe <= (s == 2'd1); fe <= (s == 2'd2);
    @(posedge clk); we <= 0; oe <= 0; fe <= 0;
  endtask
  task automatic chk(input [7:0] g, input [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    foreach (rows[i]) begin
      wreg(rows[i][19:14], rows[i][13:6]);
      pulse(rows[i][5:4]);
      cyc(2);
      chk({4'h0, wi, ei, ri, ti}, {4'h0, rows[i][3:0]});
      chk({7'h0, io}, {7'h0, |rows[i][3:0]});
      wreg(rows[i][19:14], 8'h00);
      wreg(6'h04, 8'hc3);
    end
    $display("row table done");
    // init mode: gated bits held, sensitivity kept, writes refused
    wreg(6'h05, 8'hff);
    @(posedge clk); ir <= 1; ia <= 1;
    cyc(3);
    rreg(6'h05, d); chk(d, 8'h3c);
    wreg(6'h05, 8'h00);
    rreg(6'h05, d); chk(d, 8'h3c);
    @(posedge clk); ia <= 0;
    wreg(6'h05, 8'h81);
    rreg(6'h05, d); chk(d, 8'h3c);
    @(posedge clk); ir <= 0;
    wreg(6'h05, 8'h44);
    rreg(6'h05, d); chk(d, 8'h44);
    $display("init test done");
    // tx sensitivity bus-off only, boundary at 255
    @(posedge clk); tec <= 9'd255;
    cyc(3); chk({6'h0, ts}, {6'h0, `CRE_ST_PASSIVE});
    chk({7'h0, ei}, 8'h00);
    @(posedge clk); tec <= 9'd256;
    cyc(3); chk({4'h0, rs, ts}, {4'h0, `CRE_ST_BUSOFF, `CRE_ST_BUSOFF});
    chk({7'h0, ei}, 8'h01);
    rreg(6'h04, d); chk(d, 8'h7c);
    // receiver counter high while tx drops out of a held bus-off
    @(posedge clk); tec <= 9'd0;
    rec <= 9'd100;
    cyc(3); chk({6'h0, ts}, {6'h0, `CRE_ST_BUSOFF});
    wreg(6'h04, 8'h40);
    cyc(3); chk({4'h0, rs, ts}, 8'h00);
    chk({7'h0, ei}, 8'h01);
    wreg(6'h04, 8'h40);
    cyc(3); chk({7'h0, ei}, 8'h00);
    chk({6'h0, rs}, {6'h0, `CRE_ST_WARNING});
    // receiver back to active with its sensitivity off: no flag
    @(posedge clk);
    rec <= 9'd0;
    cyc(3);
    chk({6'h0, rs}, {6'h0, `CRE_ST_ACTIVE});
    chk({7'h0, ei}, 8'h00);
    $display("tx state test done");
    // every rx sensitivity code against warning and passive steps
    for (int s = 0; s < 4; s++) begin
      wreg(6'h05, {2'b01, s[1:0], 4'h0});
      @(posedge clk); rec <= 9'd100;
      cyc(3); chk({7'h0, ei}, {7'h0, s == 3});
      wreg(6'h04, 8'h40);
      @(posedge clk); rec <= 9'd130;
      cyc(3); chk({7'h0, ei}, {7'h0, s >= 2});
      wreg(6'h04, 8'h40);
      @(posedge clk); rec <= 9'd0;
      cyc(3);
      wreg(6'h04, 8'h40);
      cyc(3);
    end
    $display("rx sensitivity test done");
    // with only enable bit 0 set, only tx empty flag 0 raises the tx request
    wreg(6'h07, 8'h01);
    @(posedge clk);
    tf <= 3'h6;
    cyc(3);
    chk({7'h0, ti}, 8'h00);
    @(posedge clk);
    tf <= 3'h1;
    cyc(3);
    chk({7'h0, ti}, 8'h01);
    chk({7'h0, io}, 8'h01);
    wreg(6'h07, 8'h00);
    $display("tx enable test done");
    // mid-run reset, then unmapped read
    wreg(6'h05, 8'hff);
    @(posedge clk); rst <= 1;
    @(posedge clk); rst <= 0;
    rreg(6'h05, d); chk(d, 8'h00);
    rreg(6'h3f, d); chk(d, 8'h00);
    $display("reset test done");
    final_report();
  end
endmodule
`default_nettype wire
